// File: src/icsb_pkg.sv
// constants for the i2c core system bus slave
`default_nettype none
package icsb_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 10;
	localparam int BYTE_W = 8;
	localparam logic [3:0] ADDR_UNMAPPED   = 4'h0;
	localparam logic [3:0] ADDR_CONTROL    = 4'h1;
	localparam logic [3:0] ADDR_PRESC_LO   = 4'h2;
	localparam logic [3:0] ADDR_PRESC_HI   = 4'h3;
	localparam logic [3:0] ADDR_SLAVE_ADDR = 4'h4;
	localparam logic [3:0] ADDR_INT_ENABLE = 4'h5;
	localparam logic [3:0] ADDR_THRESHOLD  = 4'h6;
	localparam logic [3:0] ADDR_COMMAND    = 4'h7;
	localparam logic [3:0] ADDR_TX_DATA    = 4'h8;
	localparam logic [3:0] ADDR_RX_DATA    = 4'h9;
	localparam logic [3:0] ADDR_GEN_CALL   = 4'hA;
	localparam logic [3:0] ADDR_STATUS     = 4'hB;
	localparam logic [3:0] ADDR_INT_STATUS = 4'hC;
	localparam logic [3:0] ADDR_QUEUE_SM   = 4'hD;
	localparam logic [3:0] ADDR_TX_COUNT   = 4'hE;
	localparam logic [3:0] ADDR_RX_COUNT   = 4'hF;
	localparam int CTRL_QUEUE_MODE_BIT = 4;
	localparam int CTRL_ENABLE_BIT     = 7;
	localparam logic [9:0] RESET_VALUE = 10'h000;
	localparam logic [7:0] BYTE_MASK   = 8'hFF;
	localparam int CORE_RESET_CYCLES = 2;
	localparam int QUEUE_DEPTH = 32;
	typedef enum logic [1:0] {ICSB_IDLE, ICSB_DECODE, ICSB_ACK} icsb_state_e;
endpackage
`default_nettype wire

// File: src/icsb_fifo.sv
// parameterised fifo with valid and ready on both sides
`default_nettype none
module icsb_fifo
	import icsb_pkg::*;
#(
	parameter int WIDTH = 10,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             flush,
	input  wire logic             inValid,
	output var  logic             inReady,
	input  wire logic [WIDTH-1:0] inData,
	output var  logic             outValid,
	input  wire logic             outReady,
	output var  logic [WIDTH-1:0] outData,
	output var  logic [$clog2(DEPTH):0] count
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wrPtr_reg;
	logic [PW-1:0]    rdPtr_reg;
	logic [PW:0]      count_reg;
	wire              doWrite = inValid && inReady;
	wire              doRead  = outValid && outReady;
	assign inReady  = (count_reg != (PW+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData  = mem[rdPtr_reg];
	assign count    = count_reg;
	always_ff @(posedge clk) begin
		if (doWrite) begin
			mem[wrPtr_reg] <= inData;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else if (flush) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (doWrite) wrPtr_reg <= wrPtr_reg + PW'(1);
			if (doRead) rdPtr_reg <= rdPtr_reg + PW'(1);
			count_reg <= count_reg + (PW+1)'(doWrite) - (PW+1)'(doRead);
		end
	end
endmodule // icsb_fifo
`default_nettype wire

// File: src/icsb_bus_slave.sv
// system bus slave and register map of one i2c core
`default_nettype none
// Contract
// R1 - respond to transactions only while bus_select is high
// R2 - everything clocked on the rising edge of the single bus clock
// R3 - strobe targets the slave; slave answers with acknowledge
// R4 - write_read high means write, low means read, sampled as level
// R5 - four-bit address selects one register of the map
// R6 - write data ten bits; byte in register mode, all bits in queue mode
// R7 - read data ten bits; byte in register mode, all bits in queue mode
// R8 - active-high acknowledge signals the transfer is accepted
// R9 - several masters go through an external arbiter; one reaches slave
// R10 - a write moves one word and takes at least three cycles
// R11 - master presents address, data, write level and strobe together
// R12 - slave decodes after strobe, may insert wait states before ack
// R13 - master holds request until ack seen, ends on next edge
// R14 - slave captures write data on the closing edge; this block captures it on the earlier edge where ack rises
// R15 - acknowledge drops when strobe drops, never outlasts the request; this block drops it one cycle after strobe drops
// R16 - a read returns one word in at least three cycles
// R17 - read data valid with acknowledge; master captures on next edge
// R18 - two independent cores exist, index 0 right, index 1 left
// R19 - control, prescale low, prescale high, slave address, interrupt at 1 to 5
// R20 - threshold and queue counters queue mode only; command register mode only
// R21 - transmit data write-only at 8, receive data read-only at 9
// R22 - general call, status, interrupt status read-only; width follows mode
// R23 - writing control register one also resets the core logic
// R24 - unmapped or read-only writes acknowledged, read zero, change nothing
module icsb_bus_slave
	import icsb_pkg::*;
#(
	parameter int         CORE_INDEX = 0,
	parameter int         DEPTH      = QUEUE_DEPTH
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              busSelect,
	input  wire logic              busStrobe,
	input  wire logic              busWriteRead,
	input  wire logic [ADDR_W-1:0] busRegisterAddress,
	input  wire logic [DATA_W-1:0] busWriteData,
	output var  logic [DATA_W-1:0] busReadData,
	output var  logic              busAck,
	output var  logic [DATA_W-1:0] txData,
	output var  logic              txValid,
	input  wire logic              txReady,
	input  wire logic [DATA_W-1:0] rxData,
	input  wire logic              rxValid,
	output var  logic              rxReady,
	input  wire logic [BYTE_W-1:0] generalCallInfo,
	input  wire logic [DATA_W-1:0] coreStatus,
	input  wire logic [DATA_W-1:0] interruptStatus,
	input  wire logic [DATA_W-1:0] queueStateStatus,
	output var  logic              coreReset,
	output var  logic [BYTE_W-1:0] controlOne,
	output var  logic [9:0]        prescale,
	output var  logic [BYTE_W-1:0] prescaleHigh,
	output var  logic [DATA_W-1:0] slaveAddress,
	output var  logic [DATA_W-1:0] interruptEnable,
	output var  logic [DATA_W-1:0] queueThreshold,
	output var  logic [BYTE_W-1:0] busCommand
);
	// ----------------------------------------------------------------
	// width helper
	// ----------------------------------------------------------------
	function automatic logic [DATA_W-1:0] modeMask(input logic q, input logic [DATA_W-1:0] v);
		modeMask = q ? v : {2'h0, v[BYTE_W-1:0]}; // R6 R7
	endfunction

	// core index 0 drives the right pins, 1 the left; otherwise identical
	localparam logic IS_LEFT = (CORE_INDEX == 1); // R18

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	icsb_state_e           state_reg;
	icsb_state_e           state_next;
	logic                  ack_reg;
	logic [DATA_W-1:0]     rdata_reg;
	logic [DATA_W-1:0]     rdata_next;
	logic [BYTE_W-1:0]     ctrl_reg;
	logic [BYTE_W-1:0]     prescLo_reg;
	logic [BYTE_W-1:0]     prescHi_reg;
	logic [DATA_W-1:0]     slvAddr_reg;
	logic [DATA_W-1:0]     intEn_reg;
	logic [DATA_W-1:0]     thresh_reg;
	logic [BYTE_W-1:0]     cmd_reg;
	logic [1:0]            rstCnt_reg;
	logic                  coreRst_reg;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire queueMode   = ctrl_reg[CTRL_QUEUE_MODE_BIT];
	wire request     = busSelect && busStrobe; // R1 R3
	wire isWrite     = busWriteRead; // R4
	wire closing     = (state_reg == ICSB_ACK) && !busStrobe;
	// capture happens on the edge ack rises, with request still stable
	wire commit      = (state_reg == ICSB_DECODE) && request;
	wire doWrite     = commit && isWrite; // R14
	wire doRead      = commit && !isWrite; // R16
	wire hitCtrl     = busRegisterAddress == ADDR_CONTROL; // R5 R19
	wire hitPrescLo  = busRegisterAddress == ADDR_PRESC_LO;
	wire hitPrescHi  = busRegisterAddress == ADDR_PRESC_HI;
	wire hitSlvAddr  = busRegisterAddress == ADDR_SLAVE_ADDR;
	wire hitIntEn    = busRegisterAddress == ADDR_INT_ENABLE;
	wire hitThresh   = (busRegisterAddress == ADDR_THRESHOLD) && queueMode; // R20
	wire hitCmd      = (busRegisterAddress == ADDR_COMMAND) && !queueMode; // R20
	wire hitTx       = busRegisterAddress == ADDR_TX_DATA; // R21
	wire hitRx       = busRegisterAddress == ADDR_RX_DATA; // R21
	wire [DATA_W-1:0] wdata = modeMask(queueMode, busWriteData); // R6

	// ----------------------------------------------------------------
	// data queues
	// ----------------------------------------------------------------
	logic [$clog2(DEPTH):0] txCount;
	logic [$clog2(DEPTH):0] rxCount;
	logic                   txInReady;
	logic                   rxOutValid;
	logic [DATA_W-1:0]      rxOutData;
	// a full transmit queue stalls the ack instead of dropping the word
	wire txStall = hitTx && isWrite && !txInReady; // R12

	icsb_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) txQueue (
		.clk      (clk),
		.rst_b    (rst_b),
		.flush    (coreRst_reg),
		.inValid  (doWrite && hitTx && txInReady),
		.inReady  (txInReady),
		.inData   (wdata),
		.outValid (txValid),
		.outReady (txReady),
		.outData  (txData),
		.count    (txCount)
	);
	icsb_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) rxQueue (
		.clk      (clk),
		.rst_b    (rst_b),
		.flush    (coreRst_reg),
		.inValid  (rxValid),
		.inReady  (rxReady),
		.inData   (rxData),
		.outValid (rxOutValid),
		.outReady (doRead && hitRx),
		.outData  (rxOutData),
		.count    (rxCount)
	);

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		rdata_next = RESET_VALUE; // R24
		case (busRegisterAddress)
			ADDR_CONTROL:    rdata_next = {2'h0, ctrl_reg};
			ADDR_PRESC_LO:   rdata_next = {2'h0, prescLo_reg};
			ADDR_PRESC_HI:   rdata_next = {2'h0, prescHi_reg};
			ADDR_SLAVE_ADDR: rdata_next = slvAddr_reg;
			ADDR_INT_ENABLE: rdata_next = intEn_reg;
			ADDR_THRESHOLD:  rdata_next = queueMode ? thresh_reg : RESET_VALUE; // R20
			ADDR_COMMAND:    rdata_next = queueMode ? RESET_VALUE : {2'h0, cmd_reg};
			ADDR_RX_DATA:    rdata_next = rxOutValid ? rxOutData : RESET_VALUE; // R21
			ADDR_GEN_CALL:   rdata_next = {2'h0, generalCallInfo}; // R22
			ADDR_STATUS:     rdata_next = coreStatus; // R22
			ADDR_INT_STATUS: rdata_next = interruptStatus; // R22
			ADDR_QUEUE_SM:   rdata_next = queueMode ? queueStateStatus : RESET_VALUE;
			ADDR_TX_COUNT:   rdata_next = queueMode ? DATA_W'(txCount) : RESET_VALUE;
			ADDR_RX_COUNT:   rdata_next = queueMode ? DATA_W'(rxCount) : RESET_VALUE;
			default:         rdata_next = RESET_VALUE; // R24
		endcase
		rdata_next = modeMask(queueMode, rdata_next); // R7
	end

	// ----------------------------------------------------------------
	// handshake
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ICSB_IDLE:   if (request) state_next = ICSB_DECODE; // R11 R12
			ICSB_DECODE: begin
				if (!request) state_next = ICSB_IDLE;
				else if (!txStall) state_next = ICSB_ACK; // R12
			end
			ICSB_ACK:    if (closing) state_next = ICSB_IDLE; // R15 R13
			default:     state_next = ICSB_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin // R2
		if (!rst_b) begin
			state_reg <= ICSB_IDLE;
			ack_reg   <= 1'b0;
			rdata_reg <= RESET_VALUE;
		end else begin
			state_reg <= state_next;
			ack_reg   <= (state_next == ICSB_ACK); // R8 R15
			if (doRead) rdata_reg <= rdata_next; // R17
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg    <= BYTE_W'(RESET_VALUE);
			prescLo_reg <= BYTE_W'(RESET_VALUE);
			prescHi_reg <= BYTE_W'(RESET_VALUE);
			slvAddr_reg <= RESET_VALUE;
			intEn_reg   <= RESET_VALUE;
			thresh_reg  <= RESET_VALUE;
			cmd_reg     <= BYTE_W'(RESET_VALUE);
		end else if (doWrite) begin // R10 R14
			if (hitCtrl) ctrl_reg <= wdata[BYTE_W-1:0];
			if (hitPrescLo) prescLo_reg <= wdata[BYTE_W-1:0];
			if (hitPrescHi) prescHi_reg <= wdata[BYTE_W-1:0];
			if (hitSlvAddr) slvAddr_reg <= wdata;
			if (hitIntEn) intEn_reg <= wdata;
			if (hitThresh) thresh_reg <= wdata;
			if (hitCmd) cmd_reg <= wdata[BYTE_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// core reset on control write
	// ----------------------------------------------------------------
	// a short pulse lets the core logic settle before the next access
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstCnt_reg  <= 2'h0;
			coreRst_reg <= 1'b0;
		end else if (doWrite && hitCtrl) begin // R23
			rstCnt_reg  <= 2'(CORE_RESET_CYCLES);
			coreRst_reg <= 1'b1;
		end else if (rstCnt_reg != 2'h0) begin
			rstCnt_reg  <= rstCnt_reg - 2'h1;
			coreRst_reg <= (rstCnt_reg != 2'h1);
		end else begin
			coreRst_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// busSelect is same-domain logic; no synchroniser needed
	assign busAck          = ack_reg;
	assign busReadData     = rdata_reg;
	assign coreReset       = coreRst_reg;
	assign controlOne      = ctrl_reg;
	assign prescale        = {prescHi_reg[1:0], prescLo_reg};
	assign prescaleHigh    = prescHi_reg;
	assign slaveAddress    = slvAddr_reg;
	assign interruptEnable = intEn_reg;
	assign queueThreshold  = thresh_reg;
	assign busCommand      = cmd_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	ack_needs_strobe_a: assert property (@(posedge clk) disable iff (!rst_b) // R15
		busAck && !busStrobe |=> !busAck)
		else $error("ack outlived strobe");
	ack_min_latency_a: assert property (@(posedge clk) disable iff (!rst_b) // R10
		$rose(busAck) |-> $past(request, 2) && $past(request))
		else $error("ack came too early");
	no_select_no_ack_a: assert property (@(posedge clk) disable iff (!rst_b) // R1
		$rose(busAck) |-> $past(busSelect))
		else $error("ack without select");
	ack_bounded_a: assert property (@(posedge clk) disable iff (!rst_b) // R12
		$rose(request) && !isWrite |-> ##[1:3] busAck or !request)
		else $error("read ack missing");
	write_stores_a: assert property (@(posedge clk) disable iff (!rst_b) // R14
		doWrite && hitIntEn |=> intEn_reg == $past(wdata))
		else $error("write not stored");
	read_data_a: assert property (@(posedge clk) disable iff (!rst_b) // R17
		doRead |=> busAck && busReadData == $past(rdata_next))
		else $error("read data not with ack");
	ctrl_reset_a: assert property (@(posedge clk) disable iff (!rst_b) // R23
		doWrite && hitCtrl |=> coreReset [*2])
		else $error("core reset missing");
	unmapped_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // R24
		doRead && busRegisterAddress == ADDR_UNMAPPED |=> busReadData == RESET_VALUE)
		else $error("unmapped read not zero");
	// tied to the read capture; a write ack still shows an older queue-mode word
	reg_mode_byte_a: assert property (@(posedge clk) disable iff (!rst_b) // R7
		doRead && !queueMode |=> busReadData[DATA_W-1:BYTE_W] == 2'h0)
		else $error("upper bits in register mode");
	select_gates_a: assert property (@(posedge clk) disable iff (!rst_b) // R1
		state_reg == ICSB_IDLE && !busSelect |=> state_reg == ICSB_IDLE)
		else $error("left idle without select");
	read_keeps_regs_a: assert property (@(posedge clk) disable iff (!rst_b) // R4
		doRead |=> $stable(ctrl_reg) && $stable(slvAddr_reg) && $stable(thresh_reg))
		else $error("read changed a register");
	cmd_gated_a: assert property (@(posedge clk) disable iff (!rst_b) // R20
		doRead && queueMode && busRegisterAddress == ADDR_COMMAND
		|=> busReadData == RESET_VALUE)
		else $error("command visible in queue mode");
	core_reset_len_a: assert property (@(posedge clk) disable iff (!rst_b) // R23
		doWrite && hitCtrl |-> ##3 !coreReset)
		else $error("core reset too long");
	data_held_a: assert property (@(posedge clk) disable iff (!rst_b) // R17
		busAck && $past(busAck) |-> $stable(busReadData))
		else $error("read data moved under ack");
	stall_holds_ack_a: assert property (@(posedge clk) disable iff (!rst_b) // R12
		state_reg == ICSB_DECODE && txStall |=> !busAck)
		else $error("ack while queue full");
	write_byte_a: assert property (@(posedge clk) disable iff (!rst_b) // R6
		doWrite && hitSlvAddr && !queueMode |=> slvAddr_reg[DATA_W-1:BYTE_W] == 2'h0)
		else $error("upper bits stored in register mode");
	presc_lo_store_a: assert property (@(posedge clk) disable iff (!rst_b) // R5
		doWrite && hitPrescLo |=> prescLo_reg == $past(busWriteData[BYTE_W-1:0]))
		else $error("prescale low not stored");
	unmapped_write_a: assert property (@(posedge clk) disable iff (!rst_b) // R24
		doWrite && busRegisterAddress == ADDR_UNMAPPED
		|=> $stable(ctrl_reg) && $stable(prescLo_reg) && $stable(cmd_reg))
		else $error("unmapped write changed state");
	rx_no_pop_a: assert property (@(posedge clk) disable iff (!rst_b) // R21
		doWrite && hitRx |=> rxCount >= $past(rxCount))
		else $error("write popped receive queue");
endmodule // icsb_bus_slave
`default_nettype wire

// File: testbench/icsb_core_model.sv
// core-side stand-in: drains the transmit queue, feeds the receive queue
`default_nettype none
module icsb_core_model
	import icsb_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              stall,
	input  wire logic              slow,
	input  wire logic [DATA_W-1:0] txData,
	input  wire logic              txValid,
	output var  logic              txReady,
	output var  logic [DATA_W-1:0] rxData,
	output var  logic              rxValid,
	input  wire logic              rxReady
);
	timeunit 1ns;
	timeprecision 1ns;
	// -----------------------------
	// queue traffic
	// -----------------------------
	logic [DATA_W-1:0] got[$];
	initial begin
		txReady = 1'b0;
		rxValid = 1'b0;
		rxData  = 10'h000;
	end
	// a slow core takes a word only every other cycle
	always @(posedge clk) begin
		if (txValid && txReady) got.push_back(txData);
		txReady <= !stall && (!slow || !txReady);
	end
	// word held until ready seen; released lines show the inverse, not stale data
	task automatic send(input logic [DATA_W-1:0] w);
		int n = 0;
		rxValid <= 1'b1;
		rxData  <= w;
		do @(posedge clk); while (rxReady !== 1'b1 && ++n < 100);
		rxValid <= 1'b0;
		rxData  <= ~w;
		@(posedge clk);
	endtask
endmodule // icsb_core_model
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the system bus slave
`default_nettype none
module tb
	import icsb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// -----------------------------
	// signals
	// -----------------------------
	logic       clk, rst_b, busSelect, busStrobe, busWriteRead, busAck;
	logic       txValid, txReady, rxValid, rxReady, coreReset, stall, slow;
	logic [3:0] busRegisterAddress;
	logic [9:0] busWriteData, busReadData, txData, rxData, coreStatus;
	logic [9:0] interruptStatus, queueStateStatus, prescale, slaveAddress;
	logic [9:0] interruptEnable, queueThreshold, q;
	logic [7:0] generalCallInfo, controlOne, prescaleHigh, busCommand;
	int         error_cnt, n_compared, cycles, resetCycles, lastCyc;

	// one master here, so no arbiter sits in front of the slave
	icsb_bus_slave icsb_bus_slave_inst (.clk, .rst_b, .busSelect, .busStrobe,
		.busWriteRead, .busRegisterAddress, .busWriteData, .busReadData, .busAck,
		.txData, .txValid, .txReady, .rxData, .rxValid, .rxReady, .generalCallInfo,
		.coreStatus, .interruptStatus, .queueStateStatus, .coreReset, .controlOne,
		.prescale, .prescaleHigh, .slaveAddress, .interruptEnable, .queueThreshold,
		.busCommand);
	icsb_core_model icsb_core_model_inst (.clk, .stall, .slow, .txData, .txValid,
		.txReady, .rxData, .rxValid, .rxReady);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard; also counts core reset cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (coreReset === 1'b1) resetCycles <= resetCycles + 1;
		if (cycles == 6000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	// -----------------------------
	// tasks
	// -----------------------------
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// request held until ack sampled high, then released on that edge
	task automatic bus(input logic s, input logic w, input logic [3:0] a,
		input logic [9:0] d);
		lastCyc = 0;
		busSelect <= s;
		busStrobe <= 1'b1;
		busWriteRead <= w;
		busRegisterAddress <= a;
		busWriteData <= d;
		do begin
			@(posedge clk);
			lastCyc++;
		end while (busAck !== 1'b1 && lastCyc < 60);
		q = busReadData;
		busStrobe <= 1'b0;
		busSelect <= 1'b0;
		busWriteRead <= ~w;
		busRegisterAddress <= ~a;
		busWriteData <= ~d;
		@(posedge clk);
		#1 chk(10'(busAck), 10'h000);
		@(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [9:0] d);
		bus(1'b1, 1'b1, a, d);
	endtask
	task automatic rd(input logic [3:0] a, input logic [9:0] e);
		bus(1'b1, 1'b0, a, 10'h000);
		chk(q, e);
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// -----------------------------
	// tests
	// -----------------------------
	initial begin
		{error_cnt, n_compared, cycles, resetCycles} = '0;
		{rst_b, busSelect, busStrobe, busWriteRead, slow} = '0;
		stall = 1'b1;
		busRegisterAddress = 4'h0;
		busWriteData = 10'h000;
		generalCallInfo = 8'h5A;
		coreStatus = 10'h2C3;
		interruptStatus = 10'h1B4;
		queueStateStatus = 10'h31E;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		for (int i = 1; i < 8; i++) rd(4'(i), 10'h000);
		$display("reset values done");
		// bit 4 stays clear so the block remains in register mode
		for (int i = 1; i < 8; i++) wr(4'(i), 10'h3E0 + 10'(i));
		chk(10'(lastCyc), 10'h003);
		for (int i = 1; i < 8; i++) rd(4'(i), i == 6 ? 10'h000 : 10'h0E0 + 10'(i));
		chk(10'(lastCyc), 10'h003);
		chk(10'(controlOne), 10'h0E1);
		chk(prescale, 10'h3E2);
		chk(10'(busCommand), 10'h0E7);
		chk(10'(prescaleHigh), 10'h0E3);
		chk(slaveAddress, 10'h0E4);
		chk(interruptEnable, 10'h0E5);
		chk(10'(resetCycles), 10'h002);
		$display("register mode done");
		rd(4'hA, 10'h05A);
		rd(4'hB, 10'h0C3);
		rd(4'hC, 10'h0B4);
		for (int i = 13; i < 16; i++) rd(4'(i), 10'h000);
		wr(4'h0, 10'h3FF);
		wr(4'hB, 10'h3FF);
		wr(4'h6, 10'h3FF);
		rd(4'h0, 10'h000);
		rd(4'h6, 10'h000);
		bus(1'b0, 1'b1, 4'h2, 10'h055);
		chk(10'(lastCyc), 10'h03C);
		chk(prescale, 10'h3E2);
		$display("refusals done");
		wr(4'h1, 10'h010);
		chk(10'(resetCycles), 10'h004);
		wr(4'h6, 10'h3A5);
		rd(4'h6, 10'h3A5);
		chk(queueThreshold, 10'h3A5);
		wr(4'h4, 10'h2F4);
		rd(4'h4, 10'h2F4);
		rd(4'h7, 10'h000);
		rd(4'hB, 10'h2C3);
		rd(4'hD, 10'h31E);
		for (int i = 0; i < 32; i++) wr(4'h8, 10'h200 + 10'(i));
		rd(4'h8, 10'h000);
		rd(4'hE, 10'h020);
		fork
			wr(4'h8, 10'h3FF);
			begin
				repeat (10) @(posedge clk);
				chk(10'(busAck), 10'h000);
				stall <= 1'b0;
				slow <= 1'b1;
			end
		join
		repeat (120) @(posedge clk);
		chk(10'(icsb_core_model_inst.got.size()), 10'h021);
		for (int i = 0; i < 33; i++) begin
			chk(icsb_core_model_inst.got[i], i == 32 ? 10'h3FF : 10'h200 + 10'(i));
		end
		rd(4'hE, 10'h000);
		$display("transmit queue done");
		icsb_core_model_inst.send(10'h3C1);
		icsb_core_model_inst.send(10'h2D2);
		icsb_core_model_inst.send(10'h1E3);
		wr(4'h9, 10'h155);
		rd(4'hF, 10'h003);
		rd(4'h9, 10'h3C1);
		rd(4'h9, 10'h2D2);
		rd(4'h9, 10'h1E3);
		rd(4'h9, 10'h000);
		$display("receive queue done");
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
